// File: common/pcsc_pkg.sv
// constants and types shared by both ends of the processor clock state link
// assumes a single 50 MHz system clock and synchronous active-high reset
package pcsc_pkg;

  // ---------------------------------------------------------------------------
  // clock states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCSC_NORMAL      = 3'h0,
    PCSC_STOP_GRANT  = 3'h1,
    PCSC_AUTO_HALT   = 3'h2,
    PCSC_QUICK_START = 3'h3,
    PCSC_SNOOP       = 3'h4,
    PCSC_SLEEP       = 3'h5,
    PCSC_DEEP_SLEEP  = 3'h6
  } pcsc_state_t;

  // ---------------------------------------------------------------------------
  // event vector layout
  // ---------------------------------------------------------------------------
  localparam int EV_W     = 5;
  localparam int EV_NMI   = 0;
  localparam int EV_MASKABLE_INTERRUPT  = 1;
  localparam int EV_INIT  = 2;
  localparam int EV_SMI   = 3;
  localparam int EV_FLUSH = 4;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int DEEP_EXIT_NS    = 30000;
  localparam int DEEP_EXIT_CYC   = (DEEP_EXIT_NS / CLK_PERIOD_NS < 1) ? 1 : DEEP_EXIT_NS / CLK_PERIOD_NS;
  localparam int QS_EXIT_CYC     = 8;
  localparam int SG_EXIT_CYC     = 10;
  localparam int SLEEP_EXIT_CYC  = 10;
  localparam int INIT_CYC        = 4;
  localparam int SNOOP_CYC       = 2;
  localparam int CNT_W           = 11;
  localparam int SNP_W           = 2;

  // low-power states in which inputs must stay still
  function automatic logic pcsc_restricted(input pcsc_state_t st);
    pcsc_restricted = (st == PCSC_QUICK_START) || (st == PCSC_SLEEP) || (st == PCSC_DEEP_SLEEP);
  endfunction

endpackage

// File: common/pcsc_link_if.sv
// link between the system controller end and the processor clock control end
// assumes both ends run on the same clk_sys
`timescale 1ns/1ps
interface pcsc_link_if;
  import pcsc_pkg::*;
  // requests toward the processor
  logic                clock_stop_request_n;
  logic                sleep_request_n;
  logic                strap_select_line;
  logic                bus_init_n;
  logic                system_mgmt_interrupt_n;
  logic                maskable_interrupt;
  logic                nonmaskable_interrupt;
  logic                soft_init_n;
  logic                cache_flush_request_n;
  logic                addr_bit20_mask_n;
  logic                probe_request_n;
  logic                priority_agent_request_n;
  logic                snoop_req;
  logic                bus_clock_running;
  logic                cpu_reset;
  // answers from the processor
  pcsc_state_t         clk_state;
  logic                stop_grant_ack;
  logic                halt_bus_cycle;

  modport dev (
    input  clock_stop_request_n, sleep_request_n, strap_select_line, bus_init_n,
    input  system_mgmt_interrupt_n, maskable_interrupt, nonmaskable_interrupt, soft_init_n,
    input  cache_flush_request_n, addr_bit20_mask_n, probe_request_n, priority_agent_request_n,
    input  snoop_req, bus_clock_running, cpu_reset,
    output clk_state, stop_grant_ack, halt_bus_cycle
  );
  modport sys (
    output clock_stop_request_n, sleep_request_n, strap_select_line, bus_init_n,
    output system_mgmt_interrupt_n, maskable_interrupt, nonmaskable_interrupt, soft_init_n,
    output cache_flush_request_n, addr_bit20_mask_n, probe_request_n, priority_agent_request_n,
    output snoop_req, bus_clock_running, cpu_reset,
    input  clk_state, stop_grant_ack, halt_bus_cycle
  );
endinterface

// File: core/pcsc_cpu_end.sv
// processor end: clock state machine with snoop, sleep and deep sleep handling
// assumes link inputs synchronous to clk_sys; stopped bus clock shown by bus_clock_running low
`timescale 1ns/1ps

// Behaviour
// R1: seven clock states, only defined transitions
// R2: halt instruction moves Normal to Auto Halt
// R3: halt break events return Auto Halt to Normal
// R4: stop request in Auto Halt grants, acknowledges
// R5: stop release returns Auto Halt, no halt cycle
// R6: management interrupt taken; return to halt silent
// R7: flush serviced in halt; mask, probe recognized
// R8: strap at reset picks Quick Start or Grant
// R9: Stop Grant snoops, latches one of each event
// R10: stop release or bus init leaves Stop Grant
// R11: after bus init re-enter Grant if requested
// R12: reset in Grant/Quick Start stays there
// R13: Sleep only from Stop Grant on request
// R14: Quick Start serves only priority agent snoops
// R15: system keeps inputs still in Quick Start
// R16: Quick Start exits only on stop release
// R17: clock stop in Sleep/Quick Start: Deep Sleep
// R18: snoop state until serviced and bus quiet
// R19: snoop from Quick Start keeps its restrictions
// R20: system holds inputs still around Sleep
// R21: reset in Sleep releases sleep and stop
// R22: Deep Sleep exits within thirty microseconds
// R23: bus clock stopped low for Deep Sleep
// R24: Quick Start to Normal takes eight clocks
module pcsc_cpu_end
  import pcsc_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // link to system controller
  pcsc_link_if.dev          lk,
  // core side
  input  wire logic         halt_instruction,
  input  wire logic         smm_return,
  input  wire logic         smm_return_halt,
  output logic [EV_W-1:0]   service_events,
  output logic              init_pulse,
  output logic              flush_ack,
  output logic              smi_taken,
  output logic              snoop_done,
  output logic              probe_seen,
  output logic              addr_mask_level,
  output logic              sys_mgmt_mode
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pcsc_state_t       state;
    pcsc_state_t       prior;
    pcsc_state_t       go_state;
    logic [CNT_W-1:0]  cnt;
    logic [SNP_W-1:0]  snp_left;
    logic              bus_init_n_ret;
    logic              from_halt;
    logic              qs_sel;
    logic              strap_taken;
    logic              smm_halt;
    logic [EV_W-1:0]   pend;
    logic [EV_W-1:0]   ev_prev;
    logic              probe_prev;
    logic              stop_grant_ack;
    logic              halt_bus_cycle;
    logic [EV_W-1:0]   service_events;
    logic              init_pulse;
    logic              flush_ack;
    logic              smi_taken;
    logic              snoop_done;
    logic              probe_seen;
    logic              addr_mask;
  } pcsc_cpu_t;

  pcsc_cpu_t s_r;
  pcsc_cpu_t s_nxt;

  localparam pcsc_cpu_t CPU_RST = '{
    state: PCSC_NORMAL, prior: PCSC_NORMAL, go_state: PCSC_NORMAL,
    default: '0
  };

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [EV_W-1:0] ev_now;
    logic [EV_W-1:0] ev_rise;
    logic            stop_req;
    logic            snoop_hit;
    pcsc_state_t     stop_tgt;
    ev_now               = '0;
    ev_now[EV_NMI]       = lk.nonmaskable_interrupt;
    ev_now[EV_MASKABLE_INTERRUPT]      = lk.maskable_interrupt;
    ev_now[EV_INIT]      = ~lk.soft_init_n;
    ev_now[EV_SMI]       = ~lk.system_mgmt_interrupt_n;
    ev_now[EV_FLUSH]     = ~lk.cache_flush_request_n;
    ev_rise              = ev_now & ~s_r.ev_prev;
    stop_req             = ~lk.clock_stop_request_n;
    stop_tgt             = s_r.qs_sel ? PCSC_QUICK_START : PCSC_STOP_GRANT; // R8
    snoop_hit            = lk.snoop_req &&
                           ((s_r.state != PCSC_QUICK_START) || !lk.priority_agent_request_n); // R14

    s_nxt                = s_r;
    s_nxt.stop_grant_ack = 1'b0;
    s_nxt.halt_bus_cycle = 1'b0;
    s_nxt.service_events = '0;
    s_nxt.init_pulse     = 1'b0;
    s_nxt.flush_ack      = 1'b0;
    s_nxt.smi_taken      = 1'b0;
    s_nxt.snoop_done     = 1'b0;
    s_nxt.probe_seen     = 1'b0;
    s_nxt.ev_prev        = ev_now;
    s_nxt.probe_prev     = lk.probe_request_n;

    if (!s_r.strap_taken) begin
      s_nxt.strap_taken = 1'b1;
      s_nxt.qs_sel      = ~lk.strap_select_line; // R8
    end else if (lk.cpu_reset) begin
      s_nxt.qs_sel     = ~lk.strap_select_line; // R8
      s_nxt.init_pulse = 1'b1;
      s_nxt.cnt        = '0;
      s_nxt.pend       = '0;
      s_nxt.bus_init_n_ret  = 1'b0;
      s_nxt.smm_halt   = 1'b0;
      s_nxt.from_halt  = 1'b0;
      if ((s_r.state == PCSC_STOP_GRANT) || (s_r.state == PCSC_QUICK_START)) begin
        s_nxt.state = s_r.state; // R12
      end else begin
        s_nxt.state = PCSC_NORMAL; // R21
      end
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.state == PCSC_STOP_GRANT) begin
        s_nxt.pend = s_r.pend | ev_rise; // R9
      end
      if (s_r.cnt == CNT_W'(1)) begin
        s_nxt.bus_init_n_ret = 1'b0;
        if (s_r.bus_init_n_ret && stop_req) begin
          s_nxt.state          = PCSC_STOP_GRANT; // R11
          s_nxt.stop_grant_ack = 1'b1;
        end else begin
          s_nxt.state = s_r.go_state;
          if (s_r.go_state == PCSC_NORMAL) begin
            s_nxt.service_events = s_nxt.pend; // R9
            s_nxt.pend           = '0;
            s_nxt.from_halt      = 1'b0;
          end
        end
      end
    end else begin
      case (s_r.state)
        PCSC_NORMAL: begin
          if (s_r.smm_halt && smm_return_halt) begin
            s_nxt.state    = PCSC_AUTO_HALT; // R6
            s_nxt.smm_halt = 1'b0;
          end else if (s_r.smm_halt && smm_return) begin
            s_nxt.smm_halt = 1'b0; // R6
          end else if (stop_req) begin
            s_nxt.state          = stop_tgt;
            s_nxt.stop_grant_ack = 1'b1;
            s_nxt.from_halt      = 1'b0;
          end else if (halt_instruction) begin
            s_nxt.state          = PCSC_AUTO_HALT; // R2
            s_nxt.halt_bus_cycle = 1'b1;
          end
        end
        PCSC_AUTO_HALT: begin
          s_nxt.addr_mask  = ~lk.addr_bit20_mask_n; // R7
          s_nxt.probe_seen = lk.probe_request_n != s_r.probe_prev; // R7
          if (snoop_hit) begin
            s_nxt.state    = PCSC_SNOOP; // R18
            s_nxt.prior    = PCSC_AUTO_HALT;
            s_nxt.snp_left = SNP_W'(SNOOP_CYC);
          end else if (stop_req) begin
            s_nxt.state          = stop_tgt; // R4
            s_nxt.stop_grant_ack = 1'b1;
            s_nxt.from_halt      = 1'b1;
          end else if (ev_now[EV_SMI]) begin
            s_nxt.state     = PCSC_NORMAL; // R6
            s_nxt.smi_taken = 1'b1;
            s_nxt.smm_halt  = 1'b1;
          end else if (ev_rise[EV_FLUSH]) begin
            s_nxt.flush_ack = 1'b1; // R7
          end else if (ev_now[EV_NMI] || ev_now[EV_MASKABLE_INTERRUPT] || ev_now[EV_INIT] || !lk.bus_init_n) begin
            s_nxt.state = PCSC_NORMAL; // R3
          end
        end
        PCSC_STOP_GRANT: begin
          s_nxt.pend = s_r.pend | ev_rise; // R9
          if (!lk.bus_init_n) begin
            s_nxt.init_pulse = 1'b1; // R10
            s_nxt.bus_init_n_ret  = 1'b1;
            s_nxt.go_state   = PCSC_NORMAL;
            s_nxt.cnt        = CNT_W'(INIT_CYC);
          end else if (!stop_req) begin
            s_nxt.go_state = s_r.from_halt ? PCSC_AUTO_HALT : PCSC_NORMAL; // R5 R10
            s_nxt.cnt      = CNT_W'(SG_EXIT_CYC);
          end else if (snoop_hit) begin
            s_nxt.state    = PCSC_SNOOP; // R18
            s_nxt.prior    = PCSC_STOP_GRANT;
            s_nxt.snp_left = SNP_W'(SNOOP_CYC);
          end else if (!lk.sleep_request_n) begin
            s_nxt.state = PCSC_SLEEP; // R13
          end
        end
        PCSC_QUICK_START: begin
          if (snoop_hit) begin
            s_nxt.state    = PCSC_SNOOP; // R14 R18
            s_nxt.prior    = PCSC_QUICK_START;
            s_nxt.snp_left = SNP_W'(SNOOP_CYC);
          end else if (!stop_req) begin
            s_nxt.go_state = s_r.from_halt ? PCSC_AUTO_HALT : PCSC_NORMAL; // R16 R5
            s_nxt.cnt      = CNT_W'(QS_EXIT_CYC); // R24
          end else if (!lk.bus_clock_running) begin
            s_nxt.state = PCSC_DEEP_SLEEP; // R17
            s_nxt.prior = PCSC_QUICK_START;
          end
        end
        PCSC_SNOOP: begin
          if (s_r.prior == PCSC_STOP_GRANT) begin
            s_nxt.pend = s_r.pend | ev_rise; // R9
          end
          if (s_r.snp_left != '0) begin
            s_nxt.snp_left = s_r.snp_left - 1'b1;
          end else if (!lk.snoop_req && lk.priority_agent_request_n) begin
            s_nxt.state      = s_r.prior; // R18
            s_nxt.snoop_done = 1'b1;
          end
        end
        PCSC_SLEEP: begin
          if (!lk.bus_clock_running) begin
            s_nxt.state = PCSC_DEEP_SLEEP; // R17
            s_nxt.prior = PCSC_SLEEP;
          end else if (lk.sleep_request_n) begin
            s_nxt.go_state = PCSC_STOP_GRANT;
            s_nxt.cnt      = CNT_W'(SLEEP_EXIT_CYC);
          end
        end
        PCSC_DEEP_SLEEP: begin
          if (lk.bus_clock_running) begin
            s_nxt.go_state = s_r.prior; // R22
            s_nxt.cnt      = CNT_W'(DEEP_EXIT_CYC);
          end
        end
        default: begin
          s_nxt.state = PCSC_NORMAL; // R1
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= CPU_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.clk_state      = s_r.state;
  assign lk.stop_grant_ack = s_r.stop_grant_ack;
  assign lk.halt_bus_cycle = s_r.halt_bus_cycle;
  assign service_events    = s_r.service_events;
  assign init_pulse        = s_r.init_pulse;
  assign flush_ack         = s_r.flush_ack;
  assign smi_taken         = s_r.smi_taken;
  assign snoop_done        = s_r.snoop_done;
  assign probe_seen        = s_r.probe_seen;
  assign addr_mask_level   = s_r.addr_mask;
  assign sys_mgmt_mode     = s_r.smm_halt;

endmodule

// File: core/pcsc_sys_end.sv
// system controller end: drives clock-stop, sleep and bus events toward the processor
// assumes user requests synchronous to clk_sys; holds inputs still where the processor demands it
`timescale 1ns/1ps
module pcsc_sys_end
  import pcsc_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // link to processor
  pcsc_link_if.sys          lk,
  // user requests
  input  wire logic         usr_stop_req,
  input  wire logic         usr_sleep_req,
  input  wire logic         usr_clock_off,
  input  wire logic         usr_reset,
  input  wire logic         usr_quick_start,
  input  wire logic [EV_W-1:0] usr_events,
  input  wire logic         usr_bus_init,
  input  wire logic         usr_addr_mask,
  input  wire logic         usr_probe,
  input  wire logic         usr_snoop,
  input  wire logic         usr_priority,
  // status
  output pcsc_state_t       dev_state
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic            stop_n;
    logic            sleep_n;
    logic            strap;
    logic            bus_init_n_n;
    logic [EV_W-1:0] ev;
    logic            a20_n;
    logic            probe_n;
    logic            prio_n;
    logic            snoop;
    logic            clk_run;
    logic            reset;
    logic            qs_ctx;
    pcsc_state_t     dev_state;
  } pcsc_sys_t;

  pcsc_sys_t h_r;
  pcsc_sys_t h_nxt;

  localparam pcsc_sys_t SYS_RST = '{
    stop_n: 1'b1, sleep_n: 1'b1, strap: 1'b1, bus_init_n_n: 1'b1, a20_n: 1'b1,
    probe_n: 1'b1, prio_n: 1'b1, clk_run: 1'b1, dev_state: PCSC_NORMAL, default: '0
  };

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic quiet;
    logic in_qs;
    h_nxt           = h_r;
    h_nxt.dev_state = lk.clk_state;
    if (lk.clk_state != PCSC_SNOOP) begin
      h_nxt.qs_ctx = lk.clk_state == PCSC_QUICK_START;
    end
    in_qs = h_r.qs_ctx && ((lk.clk_state == PCSC_QUICK_START) || (lk.clk_state == PCSC_SNOOP));
    quiet = pcsc_restricted(lk.clk_state) || in_qs; // R15 R19 R20
    if (!quiet) begin
      h_nxt.strap   = ~usr_quick_start; // R8
      h_nxt.bus_init_n_n = ~usr_bus_init;
      h_nxt.ev      = usr_events;
      h_nxt.a20_n   = ~usr_addr_mask;
      h_nxt.probe_n = ~usr_probe;
    end
    if (!quiet || in_qs) begin
      h_nxt.prio_n = ~usr_priority; // R15 R19
      h_nxt.snoop  = usr_snoop && (!in_qs || usr_priority);
    end
    if (lk.clk_state != PCSC_DEEP_SLEEP) begin
      h_nxt.reset = usr_reset;
    end
    if (lk.clk_state == PCSC_SLEEP || lk.clk_state == PCSC_DEEP_SLEEP || lk.clk_state == PCSC_QUICK_START) begin
      h_nxt.clk_run = ~usr_clock_off; // R17 R23
    end else begin
      h_nxt.clk_run = 1'b1;
    end
    if (lk.clk_state != PCSC_DEEP_SLEEP) begin
      if (lk.clk_state != PCSC_SLEEP) h_nxt.stop_n = ~usr_stop_req; // R20
      if (lk.clk_state == PCSC_STOP_GRANT || lk.clk_state == PCSC_SLEEP) begin
        h_nxt.sleep_n = ~usr_sleep_req; // R13
      end else begin
        h_nxt.sleep_n = 1'b1;
      end
    end
    if (usr_reset && lk.clk_state == PCSC_SLEEP) begin
      h_nxt.sleep_n = 1'b1; // R21
      h_nxt.stop_n  = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      h_r <= SYS_RST;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign lk.clock_stop_request_n     = h_r.stop_n;
  assign lk.sleep_request_n          = h_r.sleep_n;
  assign lk.strap_select_line        = h_r.strap;
  assign lk.bus_init_n               = h_r.bus_init_n_n;
  assign lk.nonmaskable_interrupt    = h_r.ev[EV_NMI];
  assign lk.maskable_interrupt       = h_r.ev[EV_MASKABLE_INTERRUPT];
  assign lk.soft_init_n              = ~h_r.ev[EV_INIT];
  assign lk.system_mgmt_interrupt_n  = ~h_r.ev[EV_SMI];
  assign lk.cache_flush_request_n    = ~h_r.ev[EV_FLUSH];
  assign lk.addr_bit20_mask_n        = h_r.a20_n;
  assign lk.probe_request_n          = h_r.probe_n;
  assign lk.priority_agent_request_n = h_r.prio_n;
  assign lk.snoop_req                = h_r.snoop;
  assign lk.bus_clock_running        = h_r.clk_run;
  assign lk.cpu_reset                = h_r.reset;
  assign dev_state                   = h_r.dev_state;

endmodule

// File: verif/pcsc_link_props.sv
// concurrent checks on the link between system end and processor end
// assumes one clk_sys domain, rst synchronous active high
`timescale 1ns/1ps
module pcsc_link_props
  import pcsc_pkg::*;
(
  // clock and reset
  input logic        clk_sys,
  input logic        rst,
  // link signals
  input logic        clock_stop_request_n,
  input logic        sleep_request_n,
  input logic        bus_init_n,
  input logic        maskable_interrupt,
  input logic        cache_flush_request_n,
  input logic        snoop_req,
  input logic        bus_clock_running,
  input pcsc_state_t clk_state,
  input logic        stop_grant_ack,
  input logic        halt_bus_cycle
);
  localparam int DEEP_MAX = DEEP_EXIT_CYC + 1;
  logic [11:0] deep_cnt_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // cycles spent in deep sleep with the clock back on
  always_ff @(posedge clk_sys) begin
    if (rst || clk_state != PCSC_DEEP_SLEEP || !bus_clock_running) deep_cnt_r <= 12'h000;
    else deep_cnt_r <= deep_cnt_r + 12'h001;
  end

  chk_ack_with_grant: assert property (
    stop_grant_ack |-> clk_state inside {PCSC_STOP_GRANT, PCSC_QUICK_START} ##1 !stop_grant_ack)
    else $error("grant ack outside grant entry");
  chk_halt_cycle_entry: assert property (
    halt_bus_cycle |-> clk_state == PCSC_AUTO_HALT && $past(clk_state) == PCSC_NORMAL)
    else $error("halt cycle without entry from normal");
  chk_sleep_from_grant: assert property (
    clk_state == PCSC_SLEEP |-> $past(clk_state) inside {PCSC_STOP_GRANT, PCSC_SLEEP, PCSC_DEEP_SLEEP})
    else $error("sleep entered from wrong state");
  chk_sleep_req_state: assert property (
    !sleep_request_n |-> clk_state inside {PCSC_STOP_GRANT, PCSC_SLEEP, PCSC_DEEP_SLEEP})
    else $error("sleep request outside grant");
  chk_qs_exit_stop: assert property (
    clk_state == PCSC_QUICK_START && !clock_stop_request_n |=> clk_state != PCSC_NORMAL)
    else $error("quick start left with stop held");
  chk_qs_exit_count: assert property (
    $rose(clock_stop_request_n) && clk_state == PCSC_QUICK_START
      |-> ##7 clk_state == PCSC_QUICK_START ##[1:3] clk_state == PCSC_NORMAL)
    else $error("quick start exit count wrong");
  chk_deep_entry: assert property (
    $fell(bus_clock_running) && clk_state inside {PCSC_SLEEP, PCSC_QUICK_START} |=> clk_state == PCSC_DEEP_SLEEP)
    else $error("deep sleep not entered");
  chk_deep_exit_time: assert property (
    deep_cnt_r <= DEEP_MAX)
    else $error("deep sleep exit too late");
  chk_snoop_holds: assert property (
    clk_state == PCSC_SNOOP && snoop_req |=> clk_state == PCSC_SNOOP)
    else $error("snoop state left early");
  chk_qs_inputs_still: assert property (
    (clk_state == PCSC_QUICK_START) [*4]
      |-> $stable(maskable_interrupt) && $stable(cache_flush_request_n) && $stable(bus_init_n))
    else $error("input changed in quick start");

  cov_snoop: cover property (clk_state == PCSC_SNOOP);
  cov_deep: cover property (clk_state == PCSC_DEEP_SLEEP);
  cov_quick: cover property (clk_state == PCSC_QUICK_START);
endmodule

// File: verif/processor_clock_state_controller_test.sv
// testbench: both ends joined by the link, driven from their user sides
// assumes 50 MHz clk_sys, inputs changed on the falling edge
`timescale 1ns/1ps
module processor_clock_state_controller_test;
  import pcsc_pkg::*;
  logic            clk_sys;
  logic            rst;
  logic            halt_instruction;
  logic            smm_return_halt;
  logic [EV_W-1:0] service_events;
  logic            sys_mgmt_mode;
  logic            usr_stop_req, usr_sleep_req, usr_clock_off, usr_reset;
  logic            usr_quick_start, usr_bus_init, usr_snoop, usr_priority;
  logic [EV_W-1:0] usr_events;
  int              errors, n_tests, n_maskable_interrupt, i;

  pcsc_link_if pcsc_link_if_inst ();
  pcsc_cpu_end pcsc_cpu_end_inst (.clk_sys(clk_sys), .rst(rst), .lk(pcsc_link_if_inst),
    .halt_instruction(halt_instruction), .smm_return(1'b0), .smm_return_halt(smm_return_halt),
    .service_events(service_events), .init_pulse(), .flush_ack(), .smi_taken(), .snoop_done(),
    .probe_seen(), .addr_mask_level(), .sys_mgmt_mode(sys_mgmt_mode));
  pcsc_sys_end pcsc_sys_end_inst (.clk_sys(clk_sys), .rst(rst), .lk(pcsc_link_if_inst),
    .usr_stop_req(usr_stop_req), .usr_sleep_req(usr_sleep_req), .usr_clock_off(usr_clock_off),
    .usr_reset(usr_reset), .usr_quick_start(usr_quick_start), .usr_events(usr_events),
    .usr_bus_init(usr_bus_init), .usr_addr_mask(1'b0), .usr_probe(1'b0), .usr_snoop(usr_snoop),
    .usr_priority(usr_priority), .dev_state());
  pcsc_link_props pcsc_link_props_inst (.clk_sys(clk_sys), .rst(rst),
    .clock_stop_request_n(pcsc_link_if_inst.clock_stop_request_n),
    .sleep_request_n(pcsc_link_if_inst.sleep_request_n), .bus_init_n(pcsc_link_if_inst.bus_init_n),
    .maskable_interrupt(pcsc_link_if_inst.maskable_interrupt),
    .cache_flush_request_n(pcsc_link_if_inst.cache_flush_request_n),
    .snoop_req(pcsc_link_if_inst.snoop_req), .bus_clock_running(pcsc_link_if_inst.bus_clock_running),
    .clk_state(pcsc_link_if_inst.clk_state), .stop_grant_ack(pcsc_link_if_inst.stop_grant_ack),
    .halt_bus_cycle(pcsc_link_if_inst.halt_bus_cycle));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // falling edges, counting released interrupt pulses
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      if (service_events[EV_MASKABLE_INTERRUPT] === 1'b1) n_maskable_interrupt++;
    end
  endtask

  task automatic wait_st(input pcsc_state_t s);
    for (i = 0; i < 2000 && pcsc_link_if_inst.clk_state !== s; i++) tick(1);
    if (pcsc_link_if_inst.clk_state !== s) begin
      errors++;
      $display("wait for state %h ran out", s);
      tally_and_finish();
    end
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_halt();
    usr_sleep_req = 1'b1;
    tick(15);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_NORMAL));
    usr_sleep_req = 1'b0;
    halt_instruction = 1'b1;
    tick(1);
    halt_instruction = 1'b0;
    wait_st(PCSC_AUTO_HALT);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_AUTO_HALT));
    usr_stop_req = 1'b1;
    wait_st(PCSC_STOP_GRANT);
    usr_stop_req = 1'b0;
    wait_st(PCSC_AUTO_HALT);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_AUTO_HALT));
    usr_events[EV_SMI] = 1'b1;
    for (i = 0; i < 50 && sys_mgmt_mode !== 1'b1; i++) tick(1);
    chk(8'(sys_mgmt_mode), 8'h01);
    usr_events[EV_SMI] = 1'b0;
    smm_return_halt = 1'b1;
    tick(1);
    smm_return_halt = 1'b0;
    wait_st(PCSC_AUTO_HALT);
    usr_events[EV_NMI] = 1'b1;
    wait_st(PCSC_NORMAL);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_NORMAL));
    usr_events[EV_NMI] = 1'b0;
    $display("test halt done");
  endtask

  task automatic t_grant();
    usr_stop_req = 1'b1;
    wait_st(PCSC_STOP_GRANT);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_STOP_GRANT));
    repeat (2) begin
      usr_events[EV_MASKABLE_INTERRUPT] = 1'b1;
      tick(2);
      usr_events[EV_MASKABLE_INTERRUPT] = 1'b0;
      tick(2);
    end
    usr_bus_init = 1'b1;
    tick(2);
    usr_bus_init = 1'b0;
    tick(4);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_STOP_GRANT));
    usr_sleep_req = 1'b1;
    wait_st(PCSC_SLEEP);
    usr_clock_off = 1'b1;
    wait_st(PCSC_DEEP_SLEEP);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_DEEP_SLEEP));
    usr_clock_off = 1'b0;
    wait_st(PCSC_SLEEP);
    usr_sleep_req = 1'b0;
    wait_st(PCSC_STOP_GRANT);
    n_maskable_interrupt = 0;
    usr_stop_req = 1'b0;
    wait_st(PCSC_NORMAL);
    tick(4);
    chk(8'(n_maskable_interrupt), 8'h01);
    $display("test grant done");
  endtask

  task automatic t_quick();
    usr_quick_start = 1'b1;
    usr_reset = 1'b1;
    tick(2);
    usr_reset = 1'b0;
    tick(10);
    usr_stop_req = 1'b1;
    wait_st(PCSC_QUICK_START);
    usr_reset = 1'b1;
    tick(2);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_QUICK_START));
    usr_reset = 1'b0;
    tick(10);
    usr_priority = 1'b1;
    usr_snoop = 1'b1;
    wait_st(PCSC_SNOOP);
    usr_snoop = 1'b0;
    usr_priority = 1'b0;
    wait_st(PCSC_QUICK_START);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_QUICK_START));
    usr_clock_off = 1'b1;
    wait_st(PCSC_DEEP_SLEEP);
    usr_clock_off = 1'b0;
    wait_st(PCSC_QUICK_START);
    usr_stop_req = 1'b0;
    tick(5);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_QUICK_START));
    wait_st(PCSC_NORMAL);
    chk(8'(pcsc_link_if_inst.clk_state), 8'(PCSC_NORMAL));
    usr_quick_start = 1'b0;
    $display("test quick done");
  endtask

  initial begin
    {errors, n_tests, n_maskable_interrupt} = '0;
    {rst, halt_instruction, smm_return_halt} = 3'b100;
    {usr_stop_req, usr_sleep_req, usr_clock_off, usr_reset} = 4'h0;
    {usr_quick_start, usr_bus_init, usr_snoop, usr_priority} = 4'h0;
    usr_events = '0;
    tick(20);
    rst = 1'b0;
    tick(2);
    t_halt();
    t_grant();
    t_quick();
    tally_and_finish();
  end
endmodule
